// ---- uartrg_host.sv ----
// Host processor model driving the register port
`timescale 1ns/1ps
module uartrg_host (
    // Clock and read data
    input  wire       clk,
    input  wire [7:0] rdata,
    // Request lines
    output reg  [2:0] addr,
    output reg        rd,
    output reg        wr,
    output reg  [7:0] wdata
);
    // Idle bus at time zero
    initial begin
        addr  = 3'h0;
        rd    = 1'b0;
        wr    = 1'b0;
        wdata = 8'h00;
    end
    // Write held to the sampling edge; data inverted after so stale data is never trusted
    task put(input [2:0] a, input [7:0] d);
        begin
            @(posedge clk);
            addr  <= a;
            wdata <= d;
            wr    <= 1'b1;
            @(posedge clk);
            wr    <= 1'b0;
            wdata <= ~d;
            @(negedge clk);
        end
    endtask
    // Read data taken at the edge that samples the strobe; returns mid-cycle so side effects have settled
    task get(input [2:0] a, output [7:0] d);
        begin
            @(posedge clk);
            addr <= a;
            rd   <= 1'b1;
            @(posedge clk);
            d = rdata;
            rd <= 1'b0;
            @(negedge clk);
        end
    endtask
endmodule // uartrg_host

// ---- uartrg_map.vh ----
// Register offsets, field positions and reset values of the UART register block
`ifndef UARTRG_MAP_VH
`define UARTRG_MAP_VH
`define UARTRG_OFF_DATA      3'h0
`define UARTRG_OFF_IEN       3'h1
`define UARTRG_OFF_ISTAT     3'h2
`define UARTRG_OFF_LCTRL     3'h3
`define UARTRG_OFF_MCTRL     3'h4
`define UARTRG_OFF_LSTAT     3'h5
`define UARTRG_OFF_MSTAT     3'h6
`define UARTRG_OFF_SCRATCH   3'h7
`define UARTRG_LC_DIVACC     7
`define UARTRG_IE_RXDATA     0
`define UARTRG_IE_TXEMPTY    1
`define UARTRG_IE_RXLINE     2
`define UARTRG_IE_MODEM      3
`define UARTRG_IE_SPECIAL    5
`define UARTRG_FC_ENABLE     0
`define UARTRG_FC_RXRST      1
`define UARTRG_FC_TXRST      2
`define UARTRG_MC_SOFTRST    2
`define UARTRG_MC_INTEN      3
`define UARTRG_MC_PWRDN      7
`define UARTRG_RST_BYTE      8'h00
`define UARTRG_RST_DIV_LOW   8'h01
`define UARTRG_IS_NONE       4'h1
`define UARTRG_IS_LINE       4'h6
`define UARTRG_IS_RXDATA     4'h4
`define UARTRG_IS_TRANSMIT_READY_STATUS      4'h2
`define UARTRG_IS_MODEM      4'h0
`define UARTRG_FIFO_DEPTH    16
`endif

// ---- uartrg_regs.v ----
// UART host register set with receive and transmit FIFO status and interrupt status
`timescale 1ns/1ps
`include "uartrg_map.vh"
module uartrg_regs (
    // Clock and reset
    input  wire       CORE_CLK,
    input  wire       RST_N,
    // Host register port
    input  wire [2:0] ADDR,
    input  wire       RD,
    input  wire       WR,
    input  wire [7:0] WDATA,
    output reg  [7:0] RDATA,
    output wire       INT_OUT,
    // Receive side from shift register
    input  wire       RX_LOAD,
    input  wire [7:0] RX_CHAR,
    input  wire [2:0] RX_ERR,
    // Transmit side to shift register
    input  wire       TX_TAKE,
    input  wire       TX_SHIFT_BUSY,
    output wire       TX_AVAIL,
    output wire [7:0] TX_CHAR,
    // Modem pins and status
    input  wire [7:0] MODEM_STATUS_IN,
    output wire [7:0] LINE_CONTROL,
    output wire [15:0] DIVISOR,
    output wire       SOFT_RESET_OUT,
    output wire       POWER_DOWN,
    output wire [1:0] MODEM_OUTPUTS
);
    // Host-programmed control registers
    reg  [7:0]  ien_q;
    reg  [7:0]  lctrl_q;
    reg  [7:0]  mctrl_q;
    reg  [7:0]  scratch_q;
    reg  [7:0]  dlow_q;
    reg  [7:0]  dhigh_q;
    reg         fen_q;
    reg  [1:0]  rxtrig_q;
    reg  [1:0]  txtrig_q;

    // Receive FIFO: eleven bits per entry, data plus three error tags
    reg  [10:0] rxmem_q [0:15];
    reg  [3:0]  rxrd_q;
    reg  [3:0]  rxwr_q;
    reg  [4:0]  rxcnt_q;
    reg  [15:0] rxbad_q;
    reg         overrun_q;

    // Transmit FIFO storage and pointers
    reg  [7:0]  txmem_q [0:15];
    reg  [3:0]  txrd_q;
    reg  [3:0]  txwr_q;
    reg  [4:0]  txcnt_q;

    // Pending interrupt flags that need an explicit acknowledge
    reg         lsint_q;
    reg         msint_q;
    reg         txint_q;

    // Mode decode
    wire        divacc = lctrl_q[`UARTRG_LC_DIVACC];
    wire        special = ien_q[`UARTRG_IE_SPECIAL];

    // Access strobes; the data offset is hidden while the divisor window is open
    wire        wr_data = WR && ADDR == `UARTRG_OFF_DATA && !divacc;
    wire        rd_data = RD && ADDR == `UARTRG_OFF_DATA && !divacc;
    wire        wr_fc = WR && ADDR == `UARTRG_OFF_ISTAT;

    // FIFO resets only act when the enable bit is written as one in the same access
    wire        fc_rxrst = wr_fc && WDATA[`UARTRG_FC_ENABLE] && WDATA[`UARTRG_FC_RXRST];
    wire        fc_txrst = wr_fc && WDATA[`UARTRG_FC_ENABLE] && WDATA[`UARTRG_FC_TXRST];

    // Single-character mode is a FIFO of depth one, so both modes share one datapath
    wire [4:0]  depth = fen_q ? 5'h10 : 5'h01;
    // A push into a full FIFO is dropped and never overwrites stored data
    wire        rx_push = RX_LOAD && rxcnt_q < depth;
    wire        rx_pop = rd_data && rxcnt_q != 5'h00;
    wire        tx_push = wr_data && txcnt_q < depth;
    wire        tx_pop = TX_TAKE && txcnt_q != 5'h00;

    // Decoded trigger levels
    reg  [4:0]  rx_lvl;
    reg  [4:0]  tx_lvl;
    // Trigger level decode of 1, 4, 8, 14
    always @* begin
        case (rxtrig_q)
            2'h0: rx_lvl = 5'h01;
            2'h1: rx_lvl = 5'h04;
            2'h2: rx_lvl = 5'h08;
            default: rx_lvl = 5'h0E;
        endcase
        // Transmit level is pinned to one outside special mode
        case (special ? txtrig_q : 2'h0)
            2'h0: tx_lvl = 5'h01;
            2'h1: tx_lvl = 5'h04;
            2'h2: tx_lvl = 5'h08;
            default: tx_lvl = 5'h0E;
        endcase
    end

    // Receive status seen by the host
    wire        rx_ready = rxcnt_q != 5'h00;
    // In single-character mode the trigger is simply holding a character
    wire        rx_trig = fen_q ? rxcnt_q >= rx_lvl : rx_ready;
    wire [10:0] head = rxmem_q[rxrd_q];
    // Tags are masked while empty so a stale entry never reports an error
    wire [2:0]  head_err = rx_ready ? head[10:8] : 3'h0;

    // Transmit status; the all-empty flag also waits for the shift register
    wire        tx_empty = txcnt_q == 5'h00;
    wire        tx_below = txcnt_q < tx_lvl;
    wire        tx_all_empty = tx_empty && !TX_SHIFT_BUSY;

    // Line status word; the global error looks at every stored entry, not just the head
    wire        any_bad = |rxbad_q;
    wire [7:0]  lstat = {any_bad,
                         tx_all_empty,
                         tx_empty,
                         head_err,
                         overrun_q,
                         rx_ready};

    // Individually gated interrupt sources
    wire        src_line = ien_q[`UARTRG_IE_RXLINE] && (overrun_q || lsint_q);
    wire        src_rx = ien_q[`UARTRG_IE_RXDATA] && rx_trig;
    wire        src_tx = ien_q[`UARTRG_IE_TXEMPTY] && txint_q;
    wire        src_ms = ien_q[`UARTRG_IE_MODEM] && msint_q;
    reg  [3:0]  isrc;
    // Highest pending source wins; all enables clear leaves polled mode
    // Order is line status, receive data, transmit ready, modem status
    always @* begin
        if (src_line) isrc = `UARTRG_IS_LINE;
        else if (src_rx) isrc = `UARTRG_IS_RXDATA;
        else if (src_tx) isrc = `UARTRG_IS_TRANSMIT_READY_STATUS;
        else if (src_ms) isrc = `UARTRG_IS_MODEM;
        else isrc = `UARTRG_IS_NONE;
    end
    // The modem control enable bit lets the host mask the pin as a whole
    assign INT_OUT = !isrc[0] && mctrl_q[`UARTRG_MC_INTEN];
    // Ready-status bits read as zero outside special mode
    wire [7:0]  istat = {fen_q,
                         fen_q,
                         special && !rx_ready,
                         special && !tx_below,
                         isrc};

    // Read mux; divisor overlays offsets zero and one
    always @* begin
        case (ADDR)
            `UARTRG_OFF_DATA:    RDATA = divacc ? dlow_q : head[7:0];
            `UARTRG_OFF_IEN:     RDATA = divacc ? dhigh_q : ien_q;
            `UARTRG_OFF_ISTAT:   RDATA = istat;
            `UARTRG_OFF_LCTRL:   RDATA = lctrl_q;
            `UARTRG_OFF_MCTRL:   RDATA = mctrl_q;
            `UARTRG_OFF_LSTAT:   RDATA = lstat;
            `UARTRG_OFF_MSTAT:   RDATA = MODEM_STATUS_IN;
            default:             RDATA = scratch_q;
        endcase
    end

    // Control registers written by the host
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            ien_q     <= `UARTRG_RST_BYTE;
            lctrl_q   <= `UARTRG_RST_BYTE;
            mctrl_q   <= `UARTRG_RST_BYTE;
            scratch_q <= `UARTRG_RST_BYTE;
            // Divisor low resets to one so the baud generator does not divide by zero out of reset
            dlow_q    <= `UARTRG_RST_DIV_LOW;
            dhigh_q   <= `UARTRG_RST_BYTE;
            fen_q     <= 1'b0;
            rxtrig_q  <= 2'h0;
            txtrig_q  <= 2'h0;
        end else if (WR) begin
            // Reserved enable and modem control bits are stored as zero
            case (ADDR)
                `UARTRG_OFF_DATA:  if (divacc) dlow_q <= WDATA;
                `UARTRG_OFF_IEN:   if (divacc) dhigh_q <= WDATA;
                                   else ien_q <= {2'h0, WDATA[5], 1'b0, WDATA[3:0]};
                `UARTRG_OFF_ISTAT: begin
                    fen_q <= WDATA[`UARTRG_FC_ENABLE];
                    // Other fields only program while enable is written as one
                    if (WDATA[`UARTRG_FC_ENABLE]) begin
                        rxtrig_q <= WDATA[7:6];
                        txtrig_q <= WDATA[5:4];
                    end
                end
                `UARTRG_OFF_LCTRL: lctrl_q <= WDATA;
                `UARTRG_OFF_MCTRL: mctrl_q <= {WDATA[7], 2'h0, WDATA[4:0]};
                `UARTRG_OFF_SCRATCH: scratch_q <= WDATA;
                default: ;
            endcase
        end
    end

    // Receive FIFO, 11 bits wide with error tags
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            rxrd_q <= 4'h0;
            rxwr_q <= 4'h0;
            rxcnt_q <= 5'h00;
            overrun_q <= 1'b0;
            lsint_q <= 1'b0;
        end else begin
            // FIFO reset empties pointers and level; the shift register is not touched
            if (fc_rxrst) begin
                rxrd_q <= 4'h0;
                rxwr_q <= 4'h0;
                rxcnt_q <= 5'h00;
            end else begin
                // Push and pop may coincide; the level moves by their difference
                if (rx_push) rxwr_q <= fen_q ? rxwr_q + 4'h1 : rxwr_q;
                if (rx_pop) rxrd_q <= fen_q ? rxrd_q + 4'h1 : rxrd_q;
                rxcnt_q <= rxcnt_q + {4'h0, rx_push} - {4'h0, rx_pop};
            end
            // Overrun sets on a full load and clears on a status read; set wins
            if (RX_LOAD && !rx_push) overrun_q <= 1'b1;
            else if (RD && ADDR == `UARTRG_OFF_LSTAT) overrun_q <= 1'b0;
            // Error tags raise the line interrupt; a status read acknowledges it
            if (rx_push && |RX_ERR) lsint_q <= 1'b1;
            else if (RD && ADDR == `UARTRG_OFF_LSTAT) lsint_q <= 1'b0;
        end
    end

    // Storage and per-entry error flags
    // Each entry is written only in its own generate block, so every flop has one driver
    genvar gi;
    generate
        for (gi = 0; gi < `UARTRG_FIFO_DEPTH; gi = gi + 1) begin : g_ent
            always @(posedge CORE_CLK or negedge RST_N) begin
                if (!RST_N) begin
                    rxmem_q[gi] <= 11'h000;
                    txmem_q[gi] <= 8'h00;
                    rxbad_q[gi] <= 1'b0;
                end else begin
                    if (rx_push && rxwr_q == gi) rxmem_q[gi] <= {RX_ERR, RX_CHAR};
                    // A FIFO reset discards every entry, one pushed in the same cycle too
                    // Otherwise an error tag lives exactly as long as its byte
                    if (fc_rxrst) rxbad_q[gi] <= 1'b0;
                    else if (rx_push && rxwr_q == gi) rxbad_q[gi] <= |RX_ERR;
                    else if (rx_pop && rxrd_q == gi) rxbad_q[gi] <= 1'b0;
                    if (tx_push && txwr_q == gi) txmem_q[gi] <= WDATA;
                end
            end
        end
    endgenerate

    // Transmit FIFO and its ready interrupt
    always @(posedge CORE_CLK or negedge RST_N) begin
        if (!RST_N) begin
            txrd_q <= 4'h0;
            txwr_q <= 4'h0;
            txcnt_q <= 5'h00;
            txint_q <= 1'b0;
            msint_q <= 1'b0;
        end else begin
            // FIFO reset empties pointers and level; the shift register is not touched
            if (fc_txrst) begin
                txrd_q <= 4'h0;
                txwr_q <= 4'h0;
                txcnt_q <= 5'h00;
            end else begin
                // Pointers only advance in FIFO mode; single-character mode keeps reusing the entry the pointer holds
                if (tx_push) txwr_q <= fen_q ? txwr_q + 4'h1 : txwr_q;
                if (tx_pop) txrd_q <= fen_q ? txrd_q + 4'h1 : txrd_q;
                txcnt_q <= txcnt_q + {4'h0, tx_push} - {4'h0, tx_pop};
            end
            // Loading data clears the ready interrupt; dropping below the level sets it
            if (tx_push) txint_q <= 1'b0;
            else if (tx_below) txint_q <= 1'b1;
            else if (RD && ADDR == `UARTRG_OFF_ISTAT && !ien_q[`UARTRG_IE_TXEMPTY]) txint_q <= 1'b0;
            // Any delta bit raises modem interrupt; reading status clears it
            if (|MODEM_STATUS_IN[3:0]) msint_q <= 1'b1;
            else if (RD && ADDR == `UARTRG_OFF_MSTAT) msint_q <= 1'b0;
        end
    end

    // Outputs to the serial side and modem pins
    // Head of the transmit FIFO, straight from storage flops
    assign TX_AVAIL = !tx_empty;
    assign TX_CHAR = txmem_q[txrd_q];
    // Framing and baud settings pass straight to the serial side
    assign LINE_CONTROL = lctrl_q;
    assign DIVISOR = {dhigh_q, dlow_q};
    // Special functions stay inert outside special mode, so older drivers cannot trip them
    assign SOFT_RESET_OUT = special && mctrl_q[`UARTRG_MC_SOFTRST];
    assign POWER_DOWN = special && mctrl_q[`UARTRG_MC_PWRDN];
    assign MODEM_OUTPUTS = mctrl_q[1:0];
endmodule // uartrg_regs

// ---- uartrg_regs_bench.sv ----
// Self-checking bench of the UART register block
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks = num_checks + 1; if ((g) !== (e)) begin num_errors = num_errors + 1; \
    $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module uartrg_regs_bench;
    reg         clk, rst_n, rx_load, tx_take, tx_busy;
    reg  [7:0]  rx_char, v, msr_in;
    reg  [2:0]  rx_err;
    wire [2:0]  addr;
    wire        rd, wr, int_out, tx_avail, soft_rst, pwr_dn;
    wire [7:0]  wdata, rdata, tx_char;
    wire [15:0] divisor;
    wire [1:0]  modem_out;
    integer     i, num_errors, num_checks;
    uartrg_regs u_dut (.CORE_CLK(clk), .RST_N(rst_n), .ADDR(addr), .RD(rd), .WR(wr), .WDATA(wdata),
        .RDATA(rdata), .INT_OUT(int_out), .RX_LOAD(rx_load), .RX_CHAR(rx_char), .RX_ERR(rx_err),
        .TX_TAKE(tx_take), .TX_SHIFT_BUSY(tx_busy), .TX_AVAIL(tx_avail), .TX_CHAR(tx_char),
        .MODEM_STATUS_IN(msr_in), .LINE_CONTROL(), .DIVISOR(divisor), .SOFT_RESET_OUT(soft_rst),
        .POWER_DOWN(pwr_dn), .MODEM_OUTPUTS(modem_out));
    uartrg_host u_host (.clk(clk), .rdata(rdata), .addr(addr), .rd(rd), .wr(wr), .wdata(wdata));
    // Core clock, 4 ns period
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Read one register and compare
    task rc(input [2:0] a, input [7:0] e);
        begin
            u_host.get(a, v);
            `CHK(v, e)
        end
    endtask
    // One character from the receive shift register; ends mid-cycle so status has settled
    task ld(input [7:0] c, input [2:0] e);
        begin
            @(posedge clk);
            rx_load <= 1'b1;
            rx_char <= c;
            rx_err  <= e;
            @(posedge clk);
            rx_load <= 1'b0;
            rx_char <= ~c;
            @(negedge clk);
        end
    endtask
    // Verdict and end of run
    task finish_test;
        begin
            $display("checks %0d errors %0d", num_checks, num_errors);
            if (num_errors == 0 && num_checks > 0)
                $display("verification passed");
            else
                $display("verification failed");
            $finish;
        end
    endtask
    // Watchdog far beyond the expected run length
    initial begin
        #100000;
        num_errors = num_errors + 1;
        finish_test;
    end
    // Main sequence
    initial begin
        num_errors = 0;
        num_checks = 0;
        rst_n = 1'b0;
        rx_load = 1'b0;
        rx_char = 8'h00;
        rx_err = 3'h0;
        tx_take = 1'b0;
        tx_busy = 1'b0;
        msr_in = 8'hF0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        rc(3'h1, 8'h00);
        rc(3'h2, 8'h01);
        rc(3'h5, 8'h60);
        rc(3'h6, 8'hF0);
        u_host.put(3'h3, 8'h3F);
        rc(3'h3, 8'h3F);
        u_host.put(3'h7, 8'hA5);
        rc(3'h7, 8'hA5);
        u_host.put(3'h3, 8'hBF);
        u_host.put(3'h0, 8'h34);
        u_host.put(3'h1, 8'h12);
        rc(3'h0, 8'h34);
        `CHK(divisor, 16'h1234)
        u_host.put(3'h3, 8'h3F);
        rc(3'h1, 8'h00);
        // Single-character mode receive interrupt
        u_host.put(3'h4, 8'h08);
        u_host.put(3'h1, 8'h01);
        ld(8'h5A, 3'h0);
        `CHK(int_out, 1'b1)
        rc(3'h2, 8'h04);
        rc(3'h5, 8'h61);
        rc(3'h0, 8'h5A);
        `CHK(int_out, 1'b0)
        // FIFO mode with trigger level four
        u_host.put(3'h2, 8'h41);
        for (i = 1; i < 4; i = i + 1) ld(i[7:0], 3'h0);
        `CHK(int_out, 1'b0)
        ld(8'h04, 3'h0);
        `CHK(int_out, 1'b1)
        rc(3'h2, 8'hC4);
        rc(3'h0, 8'h01);
        `CHK(int_out, 1'b0)
        rc(3'h2, 8'hC1);
        rc(3'h5, 8'h61);
        for (i = 2; i < 5; i = i + 1) rc(3'h0, i[7:0]);
        rc(3'h5, 8'h60);
        // Error tags follow the head byte, global flag any byte
        ld(8'hAA, 3'h0);
        ld(8'hBB, 3'h5);
        rc(3'h5, 8'hE1);
        rc(3'h0, 8'hAA);
        rc(3'h5, 8'hF5);
        rc(3'h0, 8'hBB);
        rc(3'h5, 8'h60);
        // Seventeen loads overrun sixteen places
        for (i = 0; i < 17; i = i + 1) ld(i[7:0], 3'h0);
        rc(3'h5, 8'h63);
        rc(3'h5, 8'h61);
        u_host.put(3'h2, 8'h43);
        rc(3'h5, 8'h60);
        // Polled operation
        u_host.put(3'h1, 8'h00);
        for (i = 0; i < 5; i = i + 1) ld(i[7:0], 3'h0);
        `CHK(int_out, 1'b0)
        rc(3'h2, 8'hC1);
        u_host.put(3'h2, 8'h43);
        // Modem delta raises the modem source; a status read acknowledges it
        u_host.put(3'h1, 8'h08);
        @(posedge clk);
        msr_in <= 8'hF1;
        @(posedge clk);
        msr_in <= 8'hF0;
        rc(3'h2, 8'hC0);
        `CHK(int_out, 1'b1)
        rc(3'h6, 8'hF0);
        `CHK(int_out, 1'b0)
        // Soft reset and power down only in special mode
        u_host.put(3'h4, 8'h8F);
        `CHK({soft_rst, pwr_dn, modem_out}, 4'h3)
        u_host.put(3'h1, 8'h20);
        `CHK({soft_rst, pwr_dn, modem_out}, 4'hF)
        rc(3'h2, 8'hE1);
        u_host.put(3'h1, 8'h00);
        // Transmit path empties in two steps
        u_host.put(3'h0, 8'h77);
        `CHK({tx_avail, tx_char}, 9'h177)
        rc(3'h5, 8'h00);
        @(posedge clk);
        tx_take <= 1'b1;
        tx_busy <= 1'b1;
        @(posedge clk);
        tx_take <= 1'b0;
        rc(3'h5, 8'h20);
        @(posedge clk);
        tx_busy <= 1'b0;
        rc(3'h5, 8'h60);
        finish_test;
    end
endmodule // uartrg_regs_bench
bind uartrg_regs uartrg_sva u_sva (.CORE_CLK(CORE_CLK), .RST_N(RST_N), .ADDR(ADDR), .WR(WR), .WDATA(WDATA),
    .RDATA(RDATA), .INT_OUT(INT_OUT), .RX_LOAD(RX_LOAD), .TX_AVAIL(TX_AVAIL), .LINE_CONTROL(LINE_CONTROL),
    .DIVISOR(DIVISOR), .SOFT_RESET_OUT(SOFT_RESET_OUT));

// ---- uartrg_sva.sv ----
// Port-level checker of the UART register block
`timescale 1ns/1ps
module uartrg_sva (
    // Watched ports
    input wire        CORE_CLK,
    input wire        RST_N,
    input wire [2:0]  ADDR,
    input wire        WR,
    input wire [7:0]  WDATA,
    input wire [7:0]  RDATA,
    input wire        INT_OUT,
    input wire        RX_LOAD,
    input wire        TX_AVAIL,
    input wire [7:0]  LINE_CONTROL,
    input wire [15:0] DIVISOR,
    input wire        SOFT_RESET_OUT
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!RST_N);
    // Status reads only mean something with the divisor window closed
    wire nrm = !LINE_CONTROL[7];
    div_low_a: assert property (WR && ADDR == 3'h0 && !nrm |=> DIVISOR[7:0] == $past(WDATA))
        else $error("divisor low not written");
    div_high_a: assert property (WR && ADDR == 3'h1 && !nrm |=> DIVISOR[15:8] == $past(WDATA))
        else $error("divisor high not written");
    lc_write_a: assert property (WR && ADDR == 3'h3 |=> LINE_CONTROL == $past(WDATA))
        else $error("line control not written");
    soft_gate_a: assert property (ADDR == 3'h1 && nrm && !RDATA[5] |-> !SOFT_RESET_OUT)
        else $error("soft reset acts outside special mode");
    rx_ready_a: assert property (RX_LOAD |-> ##1 !(ADDR == 3'h5 && nrm && !RDATA[0]))
        else $error("data ready missing after load");
    err_global_a: assert property (ADDR == 3'h5 && nrm && (|RDATA[4:2]) |-> RDATA[7])
        else $error("global error clear with head error");
    thr_empty_a: assert property (ADDR == 3'h5 && nrm |-> RDATA[5] == !TX_AVAIL && (RDATA[5] || !RDATA[6]))
        else $error("transmit empty flags wrong");
    polled_quiet_a: assert property (ADDR == 3'h1 && nrm && RDATA[3:0] == 4'h0 |-> !INT_OUT)
        else $error("interrupt with all enables clear");
    no_source_a: assert property (ADDR == 3'h2 && nrm && RDATA[0] |-> !INT_OUT)
        else $error("interrupt while status shows none");
endmodule // uartrg_sva
